/* File: hw/capture_compare_unit.sv */
// capture/compare unit: registers, capture, compare and special trigger
// Operation
// RULE1: value pair is two byte registers
// RULE2: mode 0000 disables and resets unit
// RULE3: 0100 falling, 0101 rising edge capture
// RULE4: capture copies 16-bit first timer count
// RULE5: prescaled capture every fourth, sixteenth rise
// RULE6: capture sets sticky flag, software clears
// RULE7: newer capture overwrites unread value
// RULE8: pin driven as output may capture
// RULE9: timer must be synchronous while used
// RULE10: mode change may give false flag
// RULE11: prescaler cleared off, non-capture, reset
// RULE12: prescale switch keeps counter, may flag
// RULE13: compare each cycle, pin action, flag
// RULE14: 1001 match drives output low
// RULE15: 1010 match flags, pin unchanged
// RULE16: control zero forces output latch low
// RULE17: special trigger clears timer, starts conversion
// RULE18: special trigger leaves overflow flag alone
// RULE19: capture/compare use first timer
// RULE20: control bits 5:4 are duty lsbs
// RULE21: software makes pin output in compare
// RULE22: 1011 selects special event trigger
// RULE23: timer write beats trigger clear
// RULE24: 0110, 0111 prescale; 1000 drives high
// RULE25: unassigned mode codes act as disabled
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module capture_compare_unit (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// first timer
	input wire logic [15:0] timer_count_i,
	input wire logic timer_write_i,
	output logic timer_clear_o,
	// analog converter
	input wire logic adc_enable_i,
	output logic adc_start_o,
	// unit pin
	input wire logic unit_pin_i,
	output logic compare_out_o,
	// flags
	output logic unit_request_flag_o
);
	ccu_pkg::reg_req_type req;
	logic [7:0] control_q;
	logic [7:0] value_low_byte_q;
	logic [7:0] value_high_byte_q;
	logic flag_q;
	logic compare_q;
	logic capture_evt;
	logic match;
	logic match_q;
	logic [3:0] mode;
	logic cmp_mode;
	logic flag_set;
	logic flag_clr;
	logic special_hit;
	logic [7:0] status_word;

	// one write strobe aimed at one register
	function automatic logic write_to(input ccu_pkg::reg_req_type r, input logic [7:0] a);
		return r.wr && r.addr == a;
	endfunction : write_to

	// one read strobe aimed at one register
	function automatic logic read_of(input ccu_pkg::reg_req_type r, input logic [7:0] a);
		return r.rd && r.addr == a;
	endfunction : read_of

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign mode = control_q[ccu_pkg::mode_lsb +: 4];
	assign cmp_mode = ccu_pkg::is_compare(mode);

	ccu_edge_prescaler u_edge (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.mode_i(mode),
		.pin_i(unit_pin_i), // RULE8
		.capture_o(capture_evt)
	);

	ccu_match u_match (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.enable_i(cmp_mode),
		.value_i({value_high_byte_q, value_low_byte_q}),
		.count_i(timer_count_i), // RULE19
		.match_o(match)
	);

	// one action per match episode
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			match_q <= 1'b0;
		end else begin
			match_q <= match;
		end
	end

	logic match_rise;
	assign match_rise = match && !match_q && cmp_mode;

	// control register
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			control_q <= ccu_pkg::control_reset; // RULE2
		end else if (write_to(req, ccu_pkg::unit_control_addr)) begin
			control_q <= req.wdata & ccu_pkg::control_write_mask; // RULE20
		end
	end

	// value pair: software write or capture
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			value_low_byte_q <= ccu_pkg::byte_zero;
			value_high_byte_q <= ccu_pkg::byte_zero;
		end else if (capture_evt && ccu_pkg::is_capture(mode)) begin
			value_low_byte_q <= timer_count_i[7:0]; // RULE4
			value_high_byte_q <= timer_count_i[15:8]; // RULE7
		end else begin
			if (write_to(req, ccu_pkg::value_low_byte_addr)) begin
				value_low_byte_q <= req.wdata; // RULE1
			end
			if (write_to(req, ccu_pkg::value_high_byte_addr)) begin
				value_high_byte_q <= req.wdata; // RULE1
			end
		end
	end

	// request flag: hardware set wins over software clear
	assign flag_set = (capture_evt && ccu_pkg::is_capture(mode)) // RULE10
		|| (match_rise && mode inside {ccu_pkg::mode_cmp_set, ccu_pkg::mode_cmp_clear,
		ccu_pkg::mode_cmp_soft, ccu_pkg::mode_cmp_special}); // RULE15
	assign flag_clr = write_to(req, ccu_pkg::status_addr) && !req.wdata[ccu_pkg::flag_bit];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1; // RULE6
		end else if (flag_clr) begin
			flag_q <= 1'b0; // RULE6
		end
	end

	// compare output latch
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			compare_q <= 1'b0;
		end else if (write_to(req, ccu_pkg::unit_control_addr) && req.wdata == ccu_pkg::control_reset) begin
			compare_q <= 1'b0; // RULE16
		end else if (match_rise && mode == ccu_pkg::mode_cmp_set) begin
			compare_q <= 1'b1; // RULE24
		end else if (match_rise && mode == ccu_pkg::mode_cmp_clear) begin
			compare_q <= 1'b0; // RULE14
		end
	end

	// special event trigger
	assign special_hit = match_rise && mode == ccu_pkg::mode_cmp_special; // RULE22

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			timer_clear_o <= 1'b0;
			adc_start_o <= 1'b0;
		end else begin
			timer_clear_o <= special_hit && !timer_write_i; // RULE23
			adc_start_o <= special_hit && adc_enable_i; // RULE17
		end
	end

	// status word: request flag only, overflow bit never touched
	always_comb begin
		status_word = ccu_pkg::byte_zero;
		status_word[ccu_pkg::flag_bit] = flag_q; // RULE6
		status_word[ccu_pkg::overflow_bit] = 1'b0; // RULE18
	end

	// read port
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= ccu_pkg::byte_zero;
		end else if (req.rd) begin
			unique case (req.addr)
				ccu_pkg::unit_control_addr: rdata_o <= control_q;
				ccu_pkg::value_low_byte_addr: rdata_o <= value_low_byte_q;
				ccu_pkg::value_high_byte_addr: rdata_o <= value_high_byte_q;
				ccu_pkg::status_addr: rdata_o <= status_word; // RULE18
				default: rdata_o <= ccu_pkg::byte_zero;
			endcase
		end else begin
			rdata_o <= ccu_pkg::byte_zero;
		end
	end

	assign compare_out_o = compare_q;
	assign unit_request_flag_o = flag_q;

	// named steps used by the checks below
	sequence s_special_match;
		match_rise && mode == ccu_pkg::mode_cmp_special;
	endsequence

	sequence s_capture_take;
		capture_evt && ccu_pkg::is_capture(mode);
	endsequence

	sequence s_control_zero;
		write_to(req, ccu_pkg::unit_control_addr) && req.wdata == ccu_pkg::control_reset;
	endsequence

	sequence s_flag_clear_only;
		flag_clr && !flag_set;
	endsequence

	// register port
	a_low_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
		write_to(req, ccu_pkg::value_low_byte_addr) && !capture_evt |=> value_low_byte_q == $past(req.wdata))
		else $error("low byte write lost");

	a_high_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
		write_to(req, ccu_pkg::value_high_byte_addr) && !capture_evt |=> value_high_byte_q == $past(req.wdata))
		else $error("high byte write lost");

	a_read_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
		read_of(req, ccu_pkg::value_low_byte_addr) |=> rdata_o == $past(value_low_byte_q))
		else $error("low byte read wrong");

	a_read_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
		read_of(req, ccu_pkg::value_high_byte_addr) |=> rdata_o == $past(value_high_byte_q))
		else $error("high byte read wrong");

	a_read_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE1
		!req.rd |=> rdata_o == ccu_pkg::byte_zero)
		else $error("read data outside read");

	a_control_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE20
		write_to(req, ccu_pkg::unit_control_addr) |=> control_q == ($past(req.wdata) & ccu_pkg::control_write_mask))
		else $error("control write wrong");

	a_control_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE20
		!write_to(req, ccu_pkg::unit_control_addr) |=> $stable(control_q))
		else $error("control moved");

	a_control_top: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE20
		(control_q & ~ccu_pkg::control_write_mask) == ccu_pkg::byte_zero)
		else $error("control top bits set");

	a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE18
		read_of(req, ccu_pkg::status_addr) |=> !rdata_o[ccu_pkg::overflow_bit] && rdata_o[ccu_pkg::flag_bit] == $past(flag_q))
		else $error("status read wrong");

	// capture
	a_capture_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE4
		s_capture_take |=> {value_high_byte_q, value_low_byte_q} == $past(timer_count_i))
		else $error("capture value wrong");

	a_mode_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE2
		mode == ccu_pkg::mode_off |=> !capture_evt)
		else $error("capture while off");

	a_cmp_no_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE19
		cmp_mode |=> !capture_evt)
		else $error("capture in compare");

	a_off_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE25
		!ccu_pkg::is_capture(mode) && !req.wr |=> $stable({value_high_byte_q, value_low_byte_q}))
		else $error("value moved outside capture");

	a_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE25
		!ccu_pkg::is_capture(mode) && !cmp_mode && !flag_q |=> !flag_q)
		else $error("disabled unit flagged");

	// request flag
	a_flag_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
		flag_q && !flag_clr |=> flag_q)
		else $error("flag lost");

	a_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
		flag_set |=> flag_q)
		else $error("flag not set");

	a_capture_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
		s_capture_take |=> flag_q)
		else $error("capture left flag clear");

	a_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
		s_flag_clear_only |=> !flag_q)
		else $error("flag not cleared");

	a_set_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE6
		flag_set && flag_clr |=> flag_q)
		else $error("clear beat set");

	// compare
	a_match_reg: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
		cmp_mode && {value_high_byte_q, value_low_byte_q} == timer_count_i |=> match)
		else $error("match missed");

	a_out_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE14
		match_rise && mode == ccu_pkg::mode_cmp_clear && !req.wr |=> !compare_q)
		else $error("output not low");

	a_out_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE24
		match_rise && mode == ccu_pkg::mode_cmp_set && !req.wr |=> compare_q)
		else $error("output not high");

	a_soft_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE15
		mode == ccu_pkg::mode_cmp_soft && !req.wr |=> $stable(compare_q))
		else $error("pin moved");

	a_out_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE13
		!match_rise && !req.wr |=> $stable(compare_q))
		else $error("output moved without match");

	a_latch_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE16
		s_control_zero |=> !compare_q)
		else $error("latch not forced low");

	// special event trigger
	a_special_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
		s_special_match ##0 !timer_write_i |=> timer_clear_o)
		else $error("timer not cleared");

	a_special_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE22
		mode == ccu_pkg::mode_cmp_special && !req.wr |=> $stable(compare_q))
		else $error("trigger moved pin");

	a_clear_source: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE22
		!(match_rise && mode == ccu_pkg::mode_cmp_special) |=> !timer_clear_o)
		else $error("stray timer clear");

	a_clear_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
		timer_clear_o |=> !timer_clear_o)
		else $error("timer clear too long");

	a_adc_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
		s_special_match ##0 adc_enable_i |=> adc_start_o)
		else $error("conversion not started");

	a_adc_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE17
		!adc_enable_i |=> !adc_start_o)
		else $error("conversion while disabled");

	a_write_wins: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE23
		timer_write_i |=> !timer_clear_o)
		else $error("trigger beat write");
endmodule : capture_compare_unit

/* File: hw/ccu_pkg.sv */
// package: register map, mode codes and field layout of the capture/compare unit
package ccu_pkg;
	localparam logic [7:0] unit_control_addr = 8'h17;
	localparam logic [7:0] value_low_byte_addr = 8'h15;
	localparam logic [7:0] value_high_byte_addr = 8'h16;
	localparam logic [7:0] status_addr = 8'h18;
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [7:0] control_write_mask = 8'h3f;
	localparam int mode_lsb = 0;
	localparam int duty_lsb = 4;
	localparam int flag_bit = 2;
	localparam int overflow_bit = 0;
	localparam int prescale_width = 4;
	localparam logic [3:0] prescale_four_last = 4'h3;
	localparam logic [3:0] prescale_sixteen_last = 4'hf;
	localparam logic [3:0] prescale_zero = 4'h0;
	localparam logic [3:0] prescale_step = 4'h1;
	localparam logic [7:0] byte_zero = 8'h00;

	typedef enum logic [3:0] {
		mode_off = 4'h0,
		mode_cap_fall = 4'h4,
		mode_cap_rise = 4'h5,
		mode_cap_rise4 = 4'h6,
		mode_cap_rise16 = 4'h7,
		mode_cmp_set = 4'h8,
		mode_cmp_clear = 4'h9,
		mode_cmp_soft = 4'ha,
		mode_cmp_special = 4'hb
	} unit_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

	typedef struct packed {
		logic [15:0] count;
		logic write;
	} timer_view_type;

	function automatic logic is_capture(input logic [3:0] m);
		return m[3:2] == 2'b01;
	endfunction : is_capture

	function automatic logic is_compare(input logic [3:0] m);
		return m[3:2] == 2'b10;
	endfunction : is_compare
endpackage : ccu_pkg

/* File: hw/ccu_edge_prescaler.sv */
// edge detector and capture prescaler for the unit pin
`timescale 1ns/1ps
module ccu_edge_prescaler (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// control
	input wire logic [3:0] mode_i,
	input wire logic pin_i,
	// event
	output logic capture_o
);
	logic pin_q;
	logic [3:0] count_q;
	logic rise;
	logic fall;
	logic hit;

	assign rise = pin_i & ~pin_q;
	assign fall = ~pin_i & pin_q;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pin_q <= 1'b0;
		end else begin
			pin_q <= pin_i;
		end
	end

	always_comb begin
		hit = 1'b0;
		unique case (mode_i)
			ccu_pkg::mode_cap_fall: hit = fall; // RULE3
			ccu_pkg::mode_cap_rise: hit = rise; // RULE3
			ccu_pkg::mode_cap_rise4: hit = rise && count_q[1:0] == ccu_pkg::prescale_four_last[1:0]; // RULE5
			ccu_pkg::mode_cap_rise16: hit = rise && count_q == ccu_pkg::prescale_sixteen_last; // RULE5
			default: hit = 1'b0; // RULE25
		endcase
	end

	// count kept across prescale changes, cleared outside capture
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			count_q <= ccu_pkg::prescale_zero; // RULE11
		end else if (!ccu_pkg::is_capture(mode_i)) begin
			count_q <= ccu_pkg::prescale_zero; // RULE11
		end else if (rise) begin
			count_q <= count_q + ccu_pkg::prescale_step; // RULE12
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			capture_o <= 1'b0;
		end else begin
			capture_o <= hit;
		end
	end

	a_prescale_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RULE11
		!ccu_pkg::is_capture(mode_i) |=> count_q == ccu_pkg::prescale_zero) else $error("prescaler not cleared");
endmodule : ccu_edge_prescaler

/* File: hw/ccu_match.sv */
// registered 16-bit equality between value pair and timer
`timescale 1ns/1ps
module ccu_match (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// operands
	input wire logic enable_i,
	input wire logic [15:0] value_i,
	input wire logic [15:0] count_i,
	// result
	output logic match_o
);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			match_o <= 1'b0;
		end else begin
			match_o <= enable_i && value_i == count_i; // RULE13
		end
	end
endmodule : ccu_match

/* File: tb/pin_source.sv */
// partner model: external signal source that pulses the unit pin
`timescale 1ns/1ps
module pin_source (
	// clock
	input wire logic sys_clk_i,
	// command
	input wire logic start_i,
	input wire logic [4:0] count_i,
	// pin side
	output logic pin_o,
	output logic busy_o
);
	logic [6:0] phase_q = 7'h00;
	always @(posedge sys_clk_i) begin
		if (start_i) begin
			phase_q <= {count_i, 2'b00};
		end else if (phase_q != 7'h00) begin
			phase_q <= phase_q - 7'h01;
		end
	end
	// two cycles high, two low per pulse; idle low as an input pin
	assign pin_o = phase_q[1];
	assign busy_o = phase_q != 7'h00;
endmodule : pin_source

/* File: tb/test_capture_compare_unit.sv */
// testbench: registers, capture, prescaler and compare of the unit
`timescale 1ns/1ps
module test_capture_compare_unit;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic [15:0] timer_count_i = 16'h0000;
	logic timer_write_i = 1'b0, adc_enable_i = 1'b1, timer_clear_o, adc_start_o;
	logic unit_pin_i, compare_out_o, unit_request_flag_o, start = 1'b0, busy;
	logic [4:0] count = 5'h00;
	int n_errors = 0, comparisons = 0, cycles = 0;
	capture_compare_unit u_capture_compare_unit (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_count_i(timer_count_i),
		.timer_write_i(timer_write_i), .timer_clear_o(timer_clear_o), .adc_enable_i(adc_enable_i),
		.adc_start_o(adc_start_o), .unit_pin_i(unit_pin_i), .compare_out_o(compare_out_o),
		.unit_request_flag_o(unit_request_flag_o));
	pin_source u_pin_source (.sys_clk_i(sys_clk_i), .start_i(start), .count_i(count), .pin_o(unit_pin_i),
		.busy_o(busy));
	always #50 sys_clk_i = ~sys_clk_i;
	task automatic final_report();
		if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic cap(input logic [3:0] mode, input logic [4:0] n, input logic [15:0] t, input logic exp);
		logic [7:0] lo, hi;
		wr(ccu_pkg::unit_control_addr, {4'h0, mode});
		wr(ccu_pkg::status_addr, 8'h00);
		timer_count_i <= t;
		count <= n;
		start <= 1'b1;
		@(posedge sys_clk_i);
		start <= 1'b0;
		repeat (70) @(posedge sys_clk_i);
		#1 chk("capture flag", 16'(unit_request_flag_o), 16'(exp));
		if (exp) begin
			rd(ccu_pkg::value_low_byte_addr, lo);
			rd(ccu_pkg::value_high_byte_addr, hi);
			chk("captured value", {hi, lo}, t);
			rd(ccu_pkg::status_addr, lo);
			chk("status", 16'(lo), 16'h0004);
		end
	endtask : cap
	// exp holds {pin, flag, timer clear, conversion start}
	task automatic cmp(input logic [3:0] mode, input logic [3:0] exp, input logic twr, input logic aen);
		logic seen_clr, seen_adc;
		seen_clr = 1'b0;
		seen_adc = 1'b0;
		wr(ccu_pkg::unit_control_addr, {4'h0, mode});
		wr(ccu_pkg::status_addr, 8'h00);
		timer_count_i <= 16'h1234;
		timer_write_i <= twr;
		adc_enable_i <= aen;
		repeat (4) begin
			@(posedge sys_clk_i);
			#1 seen_clr |= timer_clear_o;
			seen_adc |= adc_start_o;
		end
		chk("compare out", 16'(compare_out_o), 16'(exp[3]));
		chk("compare flag", 16'(unit_request_flag_o), 16'(exp[2]));
		chk("timer clear", 16'(seen_clr), 16'(exp[1]));
		chk("adc start", 16'(seen_adc), 16'(exp[0]));
		@(posedge sys_clk_i);
		timer_count_i <= 16'h0000;
		timer_write_i <= 1'b0;
	endtask : cmp
	task automatic regs();
		logic [7:0] d;
		rd(ccu_pkg::unit_control_addr, d);
		chk("control reset", 16'(d), 16'h0000);
		wr(ccu_pkg::unit_control_addr, 8'hff);
		rd(ccu_pkg::unit_control_addr, d);
		chk("control mask", 16'(d), 16'h003f);
		rd(8'h00, d);
		chk("unmapped read", 16'(d), 16'h0000);
	endtask : regs
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		regs();
		cap(4'h5, 5'd1, 16'habcd, 1'b1);
		cap(4'h5, 5'd1, 16'h1357, 1'b1);
		cap(4'h4, 5'd1, 16'h2468, 1'b1);
		cap(4'h1, 5'd1, 16'h1111, 1'b0);
		cap(4'h0, 5'd1, 16'h2222, 1'b0);
		cap(4'h6, 5'd3, 16'h3333, 1'b0);
		cap(4'h6, 5'd1, 16'h4444, 1'b1);
		wr(ccu_pkg::unit_control_addr, 8'h00);
		cap(4'h7, 5'd15, 16'h5555, 1'b0);
		cap(4'h7, 5'd1, 16'h6666, 1'b1);
		wr(ccu_pkg::value_low_byte_addr, 8'h34);
		wr(ccu_pkg::value_high_byte_addr, 8'h12);
		cmp(4'h8, 4'hc, 1'b0, 1'b1);
		cmp(4'ha, 4'hc, 1'b0, 1'b1);
		cmp(4'hb, 4'hf, 1'b0, 1'b1);
		cmp(4'hb, 4'he, 1'b0, 1'b0);
		cmp(4'hb, 4'hd, 1'b1, 1'b1);
		wr(ccu_pkg::unit_control_addr, 8'h00);
		@(posedge sys_clk_i);
		#1 chk("latch cleared", 16'(compare_out_o), 16'h0000);
		cmp(4'h8, 4'hc, 1'b0, 1'b1);
		cmp(4'h9, 4'h4, 1'b0, 1'b1);
		cmp(4'hc, 4'h0, 1'b0, 1'b1);
		final_report();
	end
endmodule : test_capture_compare_unit
